// file: rtl/mas_top.sv
// monitor converter sequencer: apb registers, slot walker, averaging
// assumes an apb master on clk_i and a converter whose result is valid
// on adc_data_i at the last cycle of each timed conversion
//
// Notes on behaviour
// - one 16-bit converter shared by all inputs
// - per-input conversion time, 52us to 4122us
// - per-input averaging, one to 1024 samples
// - slots choose any mix of inputs
// - enabled inputs converted one after another
// - no averaging: result written at conversion end
// - averaging: accumulate, repeat passes, then write
// - results hold; reads never disturb conversion
// - mode bit: auto loops forever
// - direct mode converts until averaging done, then idles
// - trigger aborts and restarts from start
// - busy flag clears after all averaging done
// - override enable forces override code everywhere
// - 63 slots, channels may repeat
// - start and stop index bound a pass
// - direct: start to stop, repeated until averaging done
// - auto: start to stop repeatedly
// - each slot holds three-bit channel id
// - range bit picks shunt full scale
// - supply or reference low sets alarm bits
`timescale 1ns/1ps
`include "mas_params.svh"
module mas_top
  import mas_pkg::*;
#(
  parameter int unsigned CT_CYC [8] = '{
    `MAS_CT0_US * `MAS_CLK_MHZ, `MAS_CT1_US * `MAS_CLK_MHZ,
    `MAS_CT2_US * `MAS_CLK_MHZ, `MAS_CT3_US * `MAS_CLK_MHZ,
    `MAS_CT4_US * `MAS_CLK_MHZ, `MAS_CT5_US * `MAS_CLK_MHZ,
    `MAS_CT6_US * `MAS_CLK_MHZ, `MAS_CT7_US * `MAS_CLK_MHZ}
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] adc_data_i,
  output logic      [2:0]  adc_chan_o,
  output logic             adc_sample_o,
  output logic             shunt_range_o,
  input  wire logic [3:0]  supply_low_i,
  input  wire logic        ref_low_i,
  output logic             power_down_o
);
  mas_gen_t    gen_r;
  logic [10:0] ctime_r;
  logic [10:0] avg_r;
  logic [5:0]  start_r;
  logic [5:0]  stop_r;
  logic [15:0] ovr_r;
  logic [4:0]  pdmask_r;
  logic [4:0]  alarm_r;
  logic [4:0]  s1_r;
  logic [4:0]  s2_r;
  logic [4:0]  s3_r;
  logic [4:0]  filt_r;
  logic [2:0]  slot_r [`MAS_NUM_SLOTS];
  logic [15:0] res_r  [`MAS_NUM_CHAN];
  logic [25:0] acc_r  [`MAS_NUM_CHAN];
  logic [10:0] cnt_r  [`MAS_NUM_CHAN];
  logic [5:0]  pend_r;
  logic [5:0]  pend_nxt;
  mas_state_t  st_r;
  logic [5:0]  idx_r;
  logic [16:0] tmr_r;
  logic [2:0]  chan_r;
  logic        sample_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        pd_r;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        acc_ph;
  logic        wr;
  logic        trig;
  logic        slot_hit;
  logic        res_hit;
  logic [5:0]  slot_ix;
  logic [2:0]  res_ix;
  logic [2:0]  cur_id;
  logic        do_samp;
  logic        avg_done;
  logic [3:0]  avg_sh;
  logic [25:0] acc_sum;
  logic        pass_end;

  // ground and both sense inputs share the shunt fields
  function automatic logic [3:0] fld_pos(input logic [2:0] id);
    if (id == `MAS_CH_TEMP) begin
      fld_pos = 4'(`MAS_F_TEMP);
    end else if (id >= `MAS_CH_BUS0) begin
      fld_pos = 4'(`MAS_F_BUS);
    end else begin
      fld_pos = 4'(`MAS_F_SHUNT);
    end
  endfunction

  // averaging code to shift: 1,4,16,64,128,256,512,1024
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0:    avg_shift = 4'h0;
      3'h1:    avg_shift = 4'h2;
      3'h2:    avg_shift = 4'h4;
      3'h3:    avg_shift = 4'h6;
      3'h4:    avg_shift = 4'h7;
      3'h5:    avg_shift = 4'h8;
      3'h6:    avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction

  assign acc_ph   = psel_i & penable_i & pready_r;
  assign wr       = acc_ph & pwrite_i;
  assign slot_ix  = paddr_i[7:2];
  assign res_ix   = paddr_i[4:2];
  assign slot_hit = (paddr_i[11:8] == `MAS_SLOT_PAGE)
                    && (slot_ix <= `MAS_LAST_SLOT);
  assign res_hit  = (paddr_i[11:5] == `MAS_RES_PAGE)
                    && (res_ix <= `MAS_MAX_CHAN);
  assign trig     = wr && (paddr_i == `MAS_OFF_TRIG)
                    && pwdata_i[`MAS_TRIG_BIT];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (slot_hit) begin
      rd_data = {29'h0000_0000, slot_r[slot_ix]};
    end else if (res_hit) begin
      // reads only look, conversion carries on
      rd_data = {16'h0000, res_r[res_ix]};
      rd_err  = pwrite_i;
    end else begin
      case (paddr_i)
        `MAS_OFF_GEN:    rd_data = {29'h0000_0000, gen_r};
        `MAS_OFF_TRIG:   rd_data = 32'h0000_0000;
        `MAS_OFF_CTIME:  rd_data = {21'h00_0000, ctime_r};
        `MAS_OFF_AVG:    rd_data = {21'h00_0000, avg_r};
        `MAS_OFF_RANGE:  rd_data = {18'h0_0000, stop_r, 2'h0, start_r};
        `MAS_OFF_OVR:    rd_data = {16'h0000, ovr_r};
        `MAS_OFF_STAT:   rd_data = {26'h000_0000, alarm_r,
                                    st_r != MAS_IDLE};
        `MAS_OFF_PDMASK: rd_data = {27'h000_0000, pdmask_r};
        default:         rd_err  = 1'b1;
      endcase
    end
  end

  // two-cycle access: pready rises on the second penable cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel_i & penable_i & ~pready_r;
      if (psel_i & penable_i & ~pready_r) begin
        pslverr_r <= rd_err;
        prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_data;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_r    <= `MAS_RST_GEN;
      ctime_r  <= `MAS_RST_FIELD;
      avg_r    <= `MAS_RST_FIELD;
      start_r  <= `MAS_RST_IDX;
      stop_r   <= `MAS_RST_IDX;
      ovr_r    <= `MAS_RST_OVR;
      pdmask_r <= 5'h00;
    end else if (wr) begin
      case (paddr_i)
        `MAS_OFF_GEN:    gen_r    <= mas_gen_t'(pwdata_i[2:0]);
        `MAS_OFF_CTIME:  ctime_r  <= pwdata_i[10:0] & 11'h777;
        `MAS_OFF_AVG:    avg_r    <= pwdata_i[10:0] & 11'h777;
        `MAS_OFF_RANGE: begin
          start_r <= pwdata_i[5:0];
          stop_r  <= pwdata_i[`MAS_RANGE_STOP +: 6];
        end
        `MAS_OFF_OVR:    ovr_r    <= pwdata_i[15:0];
        `MAS_OFF_PDMASK: pdmask_r <= pwdata_i[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `MAS_NUM_SLOTS; i++) begin
        slot_r[i] <= `MAS_RST_SLOT;
      end
    end else if (wr && slot_hit) begin
      slot_r[slot_ix] <= pwdata_i[2:0];
    end
  end

  // alarm pins are asynchronous; filtered value moves once s2 and s3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r   <= 5'h00;
      s2_r   <= 5'h00;
      s3_r   <= 5'h00;
      filt_r <= 5'h00;
    end else begin
      s1_r   <= {ref_low_i, supply_low_i};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & filt_r);
    end
  end

  // sticky, write one to clear; a new low level wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r <= 5'h00;
      pd_r    <= 1'b0;
    end else begin
      if (wr && (paddr_i == `MAS_OFF_STAT)) begin
        alarm_r <= (alarm_r & ~pwdata_i[`MAS_STAT_ALM +: 5])
                   | filt_r;
      end else begin
        alarm_r <= alarm_r | filt_r;
      end
      pd_r <= |(alarm_r & pdmask_r);
    end
  end

  assign cur_id   = slot_r[idx_r];
  assign do_samp  = (st_r == MAS_CONV) && (tmr_r == 17'h0_0000);
  assign avg_sh   = avg_shift(avg_r[fld_pos(chan_r) +: 3]);
  assign avg_done = cnt_r[chan_r] == 11'((1 << avg_sh) - 1);
  assign acc_sum  = acc_r[chan_r] + {10'h000, adc_data_i};
  assign pass_end = (idx_r == stop_r) || (idx_r == `MAS_LAST_SLOT);

  always_comb begin
    pend_nxt = pend_r;
    if (do_samp) begin
      pend_nxt[chan_r] = ~avg_done;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || trig) begin
      pend_r <= 6'h00;
      for (int i = 0; i < `MAS_NUM_CHAN; i++) begin
        acc_r[i] <= 26'h000_0000;
        cnt_r[i] <= 11'h000;
      end
    end else if (do_samp) begin
      pend_r <= pend_nxt;
      if (avg_done) begin
        acc_r[chan_r] <= 26'h000_0000;
        cnt_r[chan_r] <= 11'h000;
      end else begin
        acc_r[chan_r] <= acc_sum;
        cnt_r[chan_r] <= cnt_r[chan_r] + 11'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `MAS_NUM_CHAN; i++) begin
        res_r[i] <= 16'h0000;
      end
    end else if (gen_r.ovr_en) begin
      for (int i = 0; i < `MAS_NUM_CHAN; i++) begin
        res_r[i] <= ovr_r;
      end
    end else if (do_samp && avg_done) begin
      // shift of zero is the plain, unaveraged result
      res_r[chan_r] <= 16'(acc_sum >> avg_sh);
    end
  end

  // pass ends at stop or at the last slot, whichever comes first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r     <= MAS_IDLE;
      idx_r    <= `MAS_RST_IDX;
      tmr_r    <= 17'h0_0000;
      chan_r   <= 3'h0;
      sample_r <= 1'b0;
    end else if (trig) begin
      st_r     <= MAS_LOAD;
      idx_r    <= start_r;
      sample_r <= 1'b0;
    end else begin
      sample_r <= do_samp;
      case (st_r)
        MAS_IDLE: st_r <= MAS_IDLE;
        MAS_LOAD: begin
          if (cur_id <= `MAS_MAX_CHAN) begin
            chan_r <= cur_id;
            tmr_r  <= 17'(CT_CYC[ctime_r[fld_pos(cur_id) +: 3]] - 1);
            st_r   <= MAS_CONV;
          end else if (!pass_end) begin
            idx_r <= idx_r + 6'h01;
          end else if (gen_r.mode || (pend_r != 6'h00)) begin
            idx_r <= start_r;
          end else begin
            st_r <= MAS_IDLE;
          end
        end
        MAS_CONV: begin
          if (tmr_r != 17'h0_0000) begin
            tmr_r <= tmr_r - 17'h0_0001;
          end else if (!pass_end) begin
            idx_r <= idx_r + 6'h01;
            st_r  <= MAS_LOAD;
          end else if (gen_r.mode) begin
            idx_r <= start_r;
            st_r  <= MAS_LOAD;
          end else if (pend_nxt != 6'h00) begin
            idx_r <= start_r;
            st_r  <= MAS_LOAD;
          end else begin
            st_r <= MAS_IDLE;
          end
        end
        default: st_r <= MAS_IDLE;
      endcase
    end
  end

  assign prdata_o      = prdata_r;
  assign pready_o      = pready_r;
  assign pslverr_o     = pslverr_r;
  assign adc_chan_o    = chan_r;
  assign adc_sample_o  = sample_r;
  assign shunt_range_o = gen_r.range;
  assign power_down_o  = pd_r;
endmodule

// file: rtl/mas_params.svh
// offsets, field positions, reset values and timing figures of the
// monitor converter sequencer; included by the top only
`ifndef MAS_PARAMS_SVH
`define MAS_PARAMS_SVH
`define MAS_CLK_MHZ      20
`define MAS_CT0_US       52
`define MAS_CT1_US       84
`define MAS_CT2_US       150
`define MAS_CT3_US       280
`define MAS_CT4_US       540
`define MAS_CT5_US       1052
`define MAS_CT6_US       2074
`define MAS_CT7_US       4122
`define MAS_OFF_GEN      12'h000
`define MAS_OFF_TRIG     12'h004
`define MAS_OFF_CTIME    12'h008
`define MAS_OFF_AVG      12'h00C
`define MAS_OFF_RANGE    12'h010
`define MAS_OFF_OVR      12'h014
`define MAS_OFF_STAT     12'h018
`define MAS_OFF_PDMASK   12'h01C
`define MAS_RES_PAGE     7'h01
`define MAS_SLOT_PAGE    4'h1
`define MAS_NUM_SLOTS    63
`define MAS_LAST_SLOT    6'h3E
`define MAS_NUM_CHAN     6
`define MAS_MAX_CHAN     3'h5
`define MAS_CH_TEMP      3'h5
`define MAS_CH_BUS0      3'h3
`define MAS_TRIG_BIT     0
`define MAS_STAT_BUSY    0
`define MAS_STAT_ALM     1
`define MAS_F_SHUNT      0
`define MAS_F_BUS        4
`define MAS_F_TEMP       8
`define MAS_RANGE_STOP   8
`define MAS_RST_GEN      3'h0
`define MAS_RST_FIELD    11'h000
`define MAS_RST_IDX      6'h00
`define MAS_RST_OVR      16'h0000
`define MAS_RST_SLOT     3'h0
`endif

// file: rtl/mas_pkg.sv
// types shared by the monitor converter sequencer
// assumes mas_params.svh sits on the include path
package mas_pkg;
  typedef struct packed {
    logic ovr_en;
    logic range;
    logic mode;
  } mas_gen_t;
  typedef enum logic [1:0] {
    MAS_IDLE = 2'b00,
    MAS_LOAD = 2'b01,
    MAS_CONV = 2'b10
  } mas_state_t;
endpackage

// file: testbench/mas_props.sv
// checker on the sequencer top ports, bound after the module
// assumes an apb master that holds each request until pready
`timescale 1ns/1ps
module mas_props (
  input logic        clk_i,
  input logic        rst_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  input logic [15:0] adc_data_i,
  input logic [2:0]  adc_chan_o,
  input logic        adc_sample_o,
  input logic        shunt_range_o,
  input logic [3:0]  supply_low_i,
  input logic        ref_low_i,
  input logic        power_down_o
);
  logic [31:0] wd_q;
  always_ff @(posedge clk_i) begin
    wd_q <= pwdata_i;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rdy;
    psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("pready timing");
  property p_inacc;
    pready_o |-> psel_i && penable_i && $past(penable_i);
  endproperty
  a_inacc: assert property (p_inacc)
    else $error("pready outside access");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err)
    else $error("stray pslverr");
  property p_trig;
    pready_o && !pwrite_i && paddr_i == 12'h004 |-> prdata_o == 32'h0;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger reads nonzero");
  property p_unmap;
    pready_o && paddr_i == 12'h1FC |-> pslverr_o;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("slot past 62 accepted");
  property p_ro;
    pready_o && pwrite_i && paddr_i inside {[12'h020:12'h034]}
      |-> pslverr_o;
  endproperty
  a_ro: assert property (p_ro)
    else $error("result write accepted");
  property p_rng;
    pready_o && pwrite_i && paddr_i == 12'h000
      |=> shunt_range_o == wd_q[1];
  endproperty
  a_rng: assert property (p_rng)
    else $error("range pin wrong");
  // a slot needs a load cycle plus at least four conversion cycles
  property p_gap;
    adc_sample_o |=> !adc_sample_o [*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("samples too close");
  property p_chan;
    adc_sample_o |-> adc_chan_o <= 3'h5;
  endproperty
  a_chan: assert property (p_chan)
    else $error("bad channel id");
  c_smp: cover property (adc_sample_o);
  c_err: cover property (pslverr_o);
  c_pd: cover property ($rose(power_down_o));
endmodule
bind mas_top mas_props u_props (
  .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .adc_data_i, .adc_chan_o,
  .adc_sample_o, .shunt_range_o, .supply_low_i, .ref_low_i,
  .power_down_o);

// file: testbench/mas_analog_model.sv
// analog side: converter output per channel, supply and ref sag pins
// assumes the channel stays put for the whole conversion
`timescale 1ns/1ps
module mas_analog_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  chan_i,
  input  wire logic [7:0]  off_i,
  input  wire logic [4:0]  sag_i,
  output logic      [15:0] data_o,
  output logic      [3:0]  supply_low_o,
  output logic             ref_low_o
);
  // filter output lags a cycle, well inside the shortest conversion
  always_ff @(posedge clk_i) begin
    data_o <= {5'h00, chan_i, off_i};
  end
  assign supply_low_o = sag_i[3:0];
  assign ref_low_o    = sag_i[4];
endmodule

// file: testbench/monitor_adc_sequencer_tb_top.sv
// self-checking bench for the monitor converter sequencer
// assumes a short conversion table and the analog model as far side
`timescale 1ns/1ps
module monitor_adc_sequencer_tb_top;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, er;
  logic        pready_o, pslverr_o, adc_sample_o, shunt_range_o;
  logic        ref_low_i, power_down_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] adc_data_i;
  logic [3:0]  supply_low_i;
  logic [2:0]  adc_chan_o;
  logic [7:0]  off;
  logic [4:0]  sag;
  int          errors, samples_checked;
  int          nsamp = 0;
  mas_top #(.CT_CYC('{4, 5, 6, 7, 8, 9, 10, 11})) dut (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .adc_data_i, .adc_chan_o,
    .adc_sample_o, .shunt_range_o, .supply_low_i, .ref_low_i,
    .power_down_o);
  mas_analog_model ana (.clk_i, .chan_i(adc_chan_o), .off_i(off),
    .sag_i(sag), .data_o(adc_data_i), .supply_low_o(supply_low_i),
    .ref_low_o(ref_low_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (adc_sample_o === 1'b1) nsamp <= nsamp + 1;
  end
  task automatic results();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) begin
      errors++;
      results();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // polls a register field; a bound that runs out ends the run
  task automatic poll(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0);
      k++;
    end while ((rd & m) !== e && k < 300);
    chk(rd & m, e);
    if (k >= 300) results();
  endtask
  task automatic t_regs();
    rdc(12'h000, 32'h0);
    rdc(12'h018, 32'h0);
    wr(12'h000, 32'h2);
    @(posedge clk_i);
    chk({31'h0, shunt_range_o}, 32'h1);
    bus(1'b0, 12'h1FC, 32'h0);
    chk({31'h0, er}, 32'h1);
    bus(1'b1, 12'h020, 32'h5);
    chk({31'h0, er}, 32'h1);
    rdc(12'h020, 32'h0);
    rdc(12'h004, 32'h0);
    wr(12'h000, 32'h0);
    $display("regs done");
  endtask
  task automatic t_direct();
    logic [2:0] ids [4] = '{3'h1, 3'h3, 3'h5, 3'h2};
    int n0;
    for (int i = 0; i < 4; i++) begin
      wr(12'h100 + 12'(4 * i), {29'h0, ids[i]});
    end
    wr(12'h010, 32'h200);
    off <= 8'h11;
    n0 = nsamp;
    wr(12'h004, 32'h1);
    rdc(12'h018, 32'h1);
    poll(12'h018, 32'h1, 32'h0);
    rdc(12'h024, 32'h111);
    rdc(12'h02C, 32'h311);
    rdc(12'h034, 32'h511);
    rdc(12'h028, 32'h0);
    chk(32'(nsamp - n0), 32'h3);
    $display("direct done");
  endtask
  task automatic t_avg();
    int n0;
    wr(12'h00C, 32'h10);
    off <= 8'h22;
    n0 = nsamp;
    wr(12'h004, 32'h1);
    poll(12'h024, 32'hFFFF, 32'h122);
    rdc(12'h02C, 32'h311);
    poll(12'h018, 32'h1, 32'h0);
    rdc(12'h02C, 32'h322);
    chk(32'(nsamp - n0), 32'd12);
    $display("avg done");
  endtask
  task automatic t_auto();
    int n;
    wr(12'h00C, 32'h0);
    off <= 8'h33;
    wr(12'h000, 32'h1);
    wr(12'h004, 32'h1);
    poll(12'h034, 32'hFFFF, 32'h533);
    off <= 8'h44;
    poll(12'h034, 32'hFFFF, 32'h544);
    off <= 8'h55;
    // shunt code 2 gives the first slot a known length
    wr(12'h008, 32'h2);
    wr(12'h004, 32'h1);
    // restart: one load cycle, six conversion cycles, then the pulse
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (adc_sample_o !== 1'b1 && n < 20);
    chk(32'(n), 32'd8);
    chk({29'h0, adc_chan_o}, 32'h1);
    poll(12'h02C, 32'hFFFF, 32'h355);
    rdc(12'h024, 32'h155);
    wr(12'h000, 32'h0);
    poll(12'h018, 32'h1, 32'h0);
    $display("auto done");
  endtask
  task automatic t_ovr();
    wr(12'h014, 32'hBEEF);
    wr(12'h000, 32'h4);
    for (int c = 0; c < 6; c++) begin
      rdc(12'h020 + 12'(4 * c), 32'hBEEF);
    end
    wr(12'h000, 32'h0);
    $display("override done");
  endtask
  task automatic t_alarm();
    wr(12'h01C, 32'h1);
    sag <= 5'h01;
    poll(12'h018, 32'h2, 32'h2);
    sag <= 5'h10;
    poll(12'h018, 32'h20, 32'h20);
    chk({31'h0, power_down_o}, 32'h1);
    sag <= 5'h00;
    // lets the pin filter drain, else a set beats the clear
    rdc(12'h01C, 32'h1);
    wr(12'h018, 32'h22);
    rdc(12'h018, 32'h0);
    chk({31'h0, power_down_o}, 32'h0);
    $display("alarm done");
  endtask
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    off = 8'h00;
    sag = 5'h00;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_direct();
    t_avg();
    t_auto();
    t_ovr();
    t_alarm();
    results();
  end
endmodule
